// ==== shared/aux_mon_consts.svh ====
// constants of the auxiliary voltage fault monitor
`ifndef AUX_MON_CONSTS_SVH
`define AUX_MON_CONSTS_SVH

// ---------------------------------------------------------------
// command codes
// ---------------------------------------------------------------
`define CMD_OV_THRESHOLD   8'hF5
`define CMD_UV_THRESHOLD   8'hF6
`define CMD_READBACK       8'hF7
`define CMD_OV_RESPONSE    8'hF8
`define CMD_UV_RESPONSE    8'hF9

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define OV_THRESHOLD_RST   16'hC266
`define UV_THRESHOLD_RST   16'hB0CC
`define OV_RESPONSE_RST    8'hBF
`define UV_RESPONSE_RST    8'hBF
`define READBACK_RST       16'h0000

// ---------------------------------------------------------------
// field positions and codes
// ---------------------------------------------------------------
`define L11_EXP_MSB        15
`define L11_EXP_LSB        11
`define L11_MANT_MSB       10
`define MODE_IGNORE        2'b00
`define MODE_RETRY         2'b10
`define MODE_HOLD          2'b11
`define RETRY_NONE         3'b000
`define RETRY_CONT         3'b111

// ---------------------------------------------------------------
// thresholds in percent
// ---------------------------------------------------------------
`define PCT_FULL           8'd100
`define UV_WARN_PCT        8'd110
`define OV_WARN_PCT        8'd90
`define OV_RECOVER_PCT     8'd95

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define MCLK_HZ            50000000
`define RETRY_UNIT_MS      35

`endif

// ==== shared/aux_mon_pkg.sv ====
// types of the auxiliary voltage fault monitor
package aux_mon_pkg;

    // response byte layout
    typedef struct packed {
        logic [1:0] mode;
        logic [2:0] retry;
        logic [2:0] delay;
    } resp_s;

    // sticky fault and warning bits
    typedef struct packed {
        logic ov_fault;
        logic uv_fault;
        logic ov_warn;
        logic uv_warn;
    } status_s;

    // command request from the bus front end
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  code;
        logic [15:0] wdata;
    } cmd_s;

    typedef enum logic [2:0] {
        ST_OFF   = 3'b000,
        ST_RUN   = 3'b001,
        ST_LATCH = 3'b010,
        ST_HOLD  = 3'b011,
        ST_RETRY = 3'b100
    } ov_state_e;

endpackage

// ==== verif/aux_host_model.sv ====
// command host issuing one request per call
`timescale 1ns/1ps

module aux_host_model (
    input  wire logic         mclk,
    output aux_mon_pkg::cmd_s cmd,
    input  wire logic [15:0]  rd_data,
    input  wire logic         rd_ack,
    input  wire logic         cmd_nack
);
    initial cmd = '0;

    // one-cycle request, answer taken in the following cycle
    task automatic send(input logic w, input logic [7:0] c,
                        input logic [15:0] d, output logic [15:0] q,
                        output logic a, output logic n);
        @(posedge mclk);
        #1;
        cmd = '{wr: w, rd: !w, code: c, wdata: d};
        @(posedge mclk);
        #1;
        // released fields show garbage, not the last value
        cmd = '{wr: 1'b0, rd: 1'b0, code: ~c, wdata: ~d};
        q = rd_data;
        a = rd_ack;
        n = cmd_nack;
    endtask
endmodule // aux_host_model

// ==== verif/aux_mon_asserts.sv ====
// concurrent checks on the auxiliary voltage fault monitor ports
`timescale 1ns/1ps
`include "aux_mon_consts.svh"

module aux_mon_asserts (
    input wire logic                 mclk,
    input wire logic                 rst_n,
    input wire logic                 ce,
    input wire aux_mon_pkg::cmd_s    cmd,
    input wire logic                 clear_faults,
    input wire logic                 write_protect,
    input wire logic                 operation_on,
    input wire logic                 bias_ok,
    input wire logic                 rd_ack,
    input wire logic                 cmd_nack,
    input wire logic                 output_enable,
    input wire logic                 alert_output_line_n,
    input wire aux_mon_pkg::status_s fault_status
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    logic known;
    assign known = cmd.code >= `CMD_OV_THRESHOLD
                   && cmd.code <= `CMD_UV_RESPONSE;

    sequence s_read;
        ce && cmd.rd && !cmd.wr && known;
    endsequence
    sequence s_ro_write;
        ce && cmd.wr && cmd.code == `CMD_READBACK;
    endsequence
    sequence s_good_write;
        ce && cmd.wr && !write_protect && known
        && cmd.code != `CMD_READBACK;
    endsequence

    AST_READ_ACK: assert property (s_read |=> rd_ack && !cmd_nack)
        else $error("read not answered");
    AST_RO_WRITE: assert property (s_ro_write |=> cmd_nack)
        else $error("readback write not refused");
    AST_PROTECT: assert property (
        ce && cmd.wr && write_protect |=> cmd_nack && !rd_ack)
        else $error("protected write not refused");
    AST_WRITE_OK: assert property (
        s_good_write |=> !cmd_nack && !rd_ack)
        else $error("legal write answered");
    AST_ALERT: assert property (
        alert_output_line_n == !(fault_status.ov_fault
                                 || fault_status.uv_fault))
        else $error("alert level wrong");
    AST_STICKY: assert property (
        fault_status.ov_fault && !(ce && clear_faults)
        |=> fault_status.ov_fault)
        else $error("fault bit dropped");
    AST_FAULT_OFF: assert property (
        $rose(fault_status.ov_fault) |-> !output_enable)
        else $error("output on at fault");
    AST_RUN_CMD: assert property (
        !operation_on || !bias_ok |-> ##[1:2] !output_enable)
        else $error("output on without run command");
    AST_ONE_ANSWER: assert property (!(rd_ack && cmd_nack))
        else $error("ack and nack together");
endmodule // aux_mon_asserts

bind aux_voltage_fault_monitor aux_mon_asserts i_aux_mon_asserts (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .cmd(cmd),
    .clear_faults(clear_faults), .write_protect(write_protect),
    .operation_on(operation_on), .bias_ok(bias_ok),
    .rd_ack(rd_ack), .cmd_nack(cmd_nack),
    .output_enable(output_enable),
    .alert_output_line_n(alert_output_line_n),
    .fault_status(fault_status)
);

// ==== verif/tb.sv ====
// self-checking testbench of the auxiliary voltage fault monitor
`timescale 1ns/1ps
`include "aux_mon_consts.svh"

`define CHK(g, e) begin checks++; if ((g) !== (e)) begin failures++; \
    $display("ERROR %0t got %h exp %h", $time, g, e); end end

module tb;
    logic mclk = 1'b0;
    logic rst_n, ce, clear_faults, write_protect, meas_valid;
    logic control_pin, operation_on, bias_ok, other_fault_off;
    logic [15:0] meas_word, rd_data, q;
    logic rd_ack, cmd_nack, output_enable, alert_output_line_n, a, n;
    aux_mon_pkg::cmd_s cmd;
    aux_mon_pkg::status_s fault_status;
    int failures, checks, cyc;
    logic [7:0] codes [5] = '{8'hF5, 8'hF6, 8'hF7, 8'hF8, 8'hF9};
    logic [15:0] rvals [5] = '{16'hC266, 16'hB0CC, 16'h0000,
                               16'h00BF, 16'h00BF};

    aux_voltage_fault_monitor #(.RETRY_UNIT_CYCLES(10))
    i_aux_voltage_fault_monitor (
        .mclk(mclk), .rst_n(rst_n), .ce(ce), .cmd(cmd),
        .clear_faults(clear_faults), .write_protect(write_protect),
        .meas_valid(meas_valid), .meas_word(meas_word),
        .control_pin(control_pin), .operation_on(operation_on),
        .bias_ok(bias_ok), .other_fault_off(other_fault_off),
        .rd_data(rd_data), .rd_ack(rd_ack), .cmd_nack(cmd_nack),
        .output_enable(output_enable),
        .alert_output_line_n(alert_output_line_n),
        .fault_status(fault_status));

    aux_host_model i_aux_host_model (.mclk(mclk), .cmd(cmd),
        .rd_data(rd_data), .rd_ack(rd_ack), .cmd_nack(cmd_nack));

    always #10 mclk = ~mclk;

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            finish_test();
        end
    end

    // ----------------------------------------
    // access and stimulus tasks
    // ----------------------------------------
    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    task automatic wr(input logic [7:0] c, input logic [15:0] d,
                      input logic en);
        i_aux_host_model.send(1'b1, c, d, q, a, n);
        `CHK({a, n}, {1'b0, en})
    endtask
    task automatic rd(input logic [7:0] c, input logic [15:0] e,
                      input logic en);
        i_aux_host_model.send(1'b0, c, 16'h0000, q, a, n);
        `CHK({a, n}, {!en, en})
        if (!en) `CHK(q, e)
    endtask
    task automatic meas(input logic [15:0] w);
        tick(1);
        meas_word = w;
        meas_valid = 1'b1;
        tick(1);
        meas_valid = 1'b0;
        meas_word = ~w;
    endtask
    task automatic clr;
        tick(1);
        clear_faults = 1'b1;
        tick(1);
        clear_faults = 1'b0;
        tick(1);
    endtask
    task automatic wait_oe(input logic v, input int lim);
        for (int i = 0; i < lim && output_enable !== v; i++) tick(1);
        `CHK(output_enable, v)
    endtask
    task automatic finish_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        {rst_n, clear_faults, write_protect, meas_valid} = '0;
        {ce, control_pin, operation_on, bias_ok} = 4'hF;
        other_fault_off = 1'b0;
        meas_word = 16'h0000;
        repeat (12) @(posedge mclk);
        #1 rst_n = 1'b1;
        for (int i = 0; i < 5; i++) rd(codes[i], rvals[i], 1'b0);
        wait_oe(1'b1, 10);
        wr(8'hF6, 16'h1234, 1'b0);
        rd(8'hF6, 16'h1234, 1'b0);
        wr(8'hF7, 16'h5555, 1'b1);
        write_protect = 1'b1;
        wr(8'hF6, 16'hB0CC, 1'b1);
        wr(8'hF8, 16'h0000, 1'b1);
        rd(8'hF6, 16'h1234, 1'b0);
        rd(8'hF7, 16'h0000, 1'b0);
        write_protect = 1'b0;
        wr(8'hF6, 16'hB0CC, 1'b0);
        rd(8'hF0, 16'h0000, 1'b1);
        wr(8'hF8, 16'h00B9, 1'b0);
        meas(16'hC2FF);
        tick(2);
        `CHK({fault_status.ov_fault, alert_output_line_n}, 2'b10)
        `CHK(output_enable, 1'b0)
        meas(16'hC200);
        tick(14);
        `CHK(output_enable, 1'b0)
        wait_oe(1'b1, 8);
        `CHK(fault_status.ov_fault, 1'b1)
        meas(16'hC2FF);
        tick(32);
        `CHK(output_enable, 1'b0)
        meas(16'hC200);
        wait_oe(1'b1, 4);
        meas(16'hC2FF);
        operation_on = 1'b0;
        meas(16'hC200);
        tick(30);
        `CHK(output_enable, 1'b0)
        operation_on = 1'b1;
        wait_oe(1'b1, 6);
        clr();
        `CHK({fault_status, alert_output_line_n}, 5'h01)
        wr(8'hF8, 16'h00C0, 1'b0);
        meas(16'hC2FF);
        meas(16'hC250);
        tick(10);
        `CHK(output_enable, 1'b0)
        meas(16'hC200);
        wait_oe(1'b1, 4);
        wr(8'hF8, 16'h0080, 1'b0);
        meas(16'hC2FF);
        meas(16'hC200);
        tick(40);
        `CHK(output_enable, 1'b0)
        clr();
        wait_oe(1'b1, 4);
        wr(8'hF8, 16'h0000, 1'b0);
        meas(16'hC2FF);
        tick(3);
        `CHK({fault_status.ov_fault, output_enable}, 2'b01)
        meas(16'hC240);
        clr();
        `CHK(fault_status, 4'b0010)
        meas(16'hB0D8);
        clr();
        `CHK(fault_status, 4'b0001)
        meas(16'hB0E8);
        clr();
        `CHK(fault_status, 4'b0000)
        meas(16'hB064);
        tick(2);
        `CHK({fault_status.uv_fault, alert_output_line_n}, 2'b10)
        wr(8'hF9, 16'h0000, 1'b0);
        clr();
        `CHK({fault_status, alert_output_line_n}, 5'h03)
        control_pin = 1'b0;
        tick(2);
        `CHK(output_enable, 1'b1)
        tick(2);
        `CHK(output_enable, 1'b0)
        control_pin = 1'b1;
        bias_ok = 1'b0;
        tick(5);
        `CHK(output_enable, 1'b0)
        bias_ok = 1'b1;
        other_fault_off = 1'b1;
        tick(5);
        `CHK(output_enable, 1'b0)
        other_fault_off = 1'b0;
        wait_oe(1'b1, 6);
        ce = 1'b0;
        wr(8'hF5, 16'h1111, 1'b0);
        ce = 1'b1;
        rd(8'hF5, 16'hC266, 1'b0);
        wr(8'hF5, 16'h1111, 1'b0);
        rd(8'hF5, 16'h1111, 1'b0);
        tick(1);
        rst_n = 1'b0;
        tick(2);
        rst_n = 1'b1;
        rd(8'hF8, 16'h00BF, 1'b0);
        rd(8'hF5, 16'hC266, 1'b0);
        finish_test();
    end
endmodule // tb

// ==== verilog/aux_voltage_fault_monitor.sv ====
// auxiliary voltage monitor: thresholds, response and fault logic
`timescale 1ns/1ps
`include "aux_mon_consts.svh"

// How it works
// - undervoltage warning trips below 110 percent of the fault threshold.
// - undervoltage response mode 00 suppresses every undervoltage fault.
// - undervoltage threshold is a read/write Linear-11 word.
// - undervoltage threshold resets to B0CC, 0.2 volts.
// - readback word is read only, shows measured voltage, never protected.
// - overvoltage response byte resets to BF.
// - mode 00 ignores faults, 10 disables at once then follows retry.
// - mode 11 holds output off until voltage below 95 percent.
// - a fault response pulls alert low and sets a sticky status bit.
// - retry 000 keeps output off until faults are cleared or the run command is removed and restored.
// - retry 111 restarts forever until commanded off or shut down.
// - each continuous retry waits for voltage below 95 percent.
// - restart interval is delay field plus one times 35 ms.
// - overvoltage warning trips above 90 percent of fault threshold.
// - overvoltage threshold resets to C266 and drives the compares.
module aux_voltage_fault_monitor #(
    parameter int RETRY_UNIT_CYCLES = `RETRY_UNIT_MS * (`MCLK_HZ / 1000),
    parameter int CNT_W             = 24,
    parameter int FX_W              = 48
) (
    input  wire logic                 mclk,
    input  wire logic                 rst_n,
    input  wire logic                 ce,
    input  wire aux_mon_pkg::cmd_s    cmd,
    input  wire logic                 clear_faults,
    input  wire logic                 write_protect,
    input  wire logic                 meas_valid,
    input  wire logic [15:0]          meas_word,
    input  wire logic                 control_pin,
    input  wire logic                 operation_on,
    input  wire logic                 bias_ok,
    input  wire logic                 other_fault_off,
    output logic [15:0]               rd_data,
    output logic                      rd_ack,
    output logic                      cmd_nack,
    output logic                      output_enable,
    output logic                      alert_output_line_n,
    output aux_mon_pkg::status_s      fault_status
);

    // ---------------------------------------------------------------
    // control pin synchroniser
    // ---------------------------------------------------------------
    logic ctl_meta_r;
    logic ctl_sync_r;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_meta_r <= 1'b0;
            ctl_sync_r <= 1'b0;
        end else if (ce) begin
            ctl_meta_r <= control_pin;
            ctl_sync_r <= ctl_meta_r;
        end
    end

    // ---------------------------------------------------------------
    // command registers
    // ---------------------------------------------------------------
    logic [15:0]        ov_thr_r;
    logic [15:0]        ov_thr_nxt;
    logic [15:0]        uv_thr_r;
    logic [15:0]        uv_thr_nxt;
    logic [15:0]        readback_r;
    logic [15:0]        readback_nxt;
    logic               seen_r;
    logic               seen_nxt;
    aux_mon_pkg::resp_s ov_resp_r;
    aux_mon_pkg::resp_s ov_resp_nxt;
    aux_mon_pkg::resp_s uv_resp_r;
    aux_mon_pkg::resp_s uv_resp_nxt;
    logic [15:0]        rd_data_r;
    logic [15:0]        rd_data_nxt;
    logic               rd_ack_r;
    logic               rd_ack_nxt;
    logic               nack_r;
    logic               nack_nxt;
    logic               known;

    always_comb begin
        ov_thr_nxt   = ov_thr_r;
        uv_thr_nxt   = uv_thr_r;
        ov_resp_nxt  = ov_resp_r;
        uv_resp_nxt  = uv_resp_r;
        readback_nxt = readback_r;
        seen_nxt     = seen_r;
        rd_data_nxt  = rd_data_r;
        rd_ack_nxt   = 1'b0;
        nack_nxt     = 1'b0;
        known        = (cmd.code == `CMD_OV_THRESHOLD)
                    || (cmd.code == `CMD_UV_THRESHOLD)
                    || (cmd.code == `CMD_READBACK)
                    || (cmd.code == `CMD_OV_RESPONSE)
                    || (cmd.code == `CMD_UV_RESPONSE);
        if (meas_valid) begin
            readback_nxt = meas_word;
            seen_nxt     = 1'b1;
        end
        if (cmd.wr) begin
            if (!known || write_protect) begin
                nack_nxt = 1'b1;
            end else if (cmd.code == `CMD_OV_THRESHOLD) begin
                ov_thr_nxt = cmd.wdata;
            end else if (cmd.code == `CMD_UV_THRESHOLD) begin
                uv_thr_nxt = cmd.wdata;
            end else if (cmd.code == `CMD_OV_RESPONSE) begin
                ov_resp_nxt = cmd.wdata[7:0];
            end else if (cmd.code == `CMD_UV_RESPONSE) begin
                uv_resp_nxt = cmd.wdata[7:0];
            end else begin
                nack_nxt = 1'b1;
            end
        end else if (cmd.rd) begin
            rd_ack_nxt = known;
            nack_nxt   = !known;
            if (cmd.code == `CMD_OV_THRESHOLD) begin
                rd_data_nxt = ov_thr_r;
            end else if (cmd.code == `CMD_UV_THRESHOLD) begin
                rd_data_nxt = uv_thr_r;
            end else if (cmd.code == `CMD_READBACK) begin
                rd_data_nxt = readback_r;
            end else if (cmd.code == `CMD_OV_RESPONSE) begin
                rd_data_nxt = {8'h00, ov_resp_r};
            end else if (cmd.code == `CMD_UV_RESPONSE) begin
                rd_data_nxt = {8'h00, uv_resp_r};
            end else begin
                rd_data_nxt = 16'h0000;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ov_thr_r   <= `OV_THRESHOLD_RST;
            uv_thr_r   <= `UV_THRESHOLD_RST;
            ov_resp_r  <= `OV_RESPONSE_RST;
            uv_resp_r  <= `UV_RESPONSE_RST;
            readback_r <= `READBACK_RST;
            seen_r     <= 1'b0;
            rd_data_r  <= 16'h0000;
            rd_ack_r   <= 1'b0;
            nack_r     <= 1'b0;
        end else if (ce) begin
            ov_thr_r   <= ov_thr_nxt;
            uv_thr_r   <= uv_thr_nxt;
            ov_resp_r  <= ov_resp_nxt;
            uv_resp_r  <= uv_resp_nxt;
            readback_r <= readback_nxt;
            seen_r     <= seen_nxt;
            rd_data_r  <= rd_data_nxt;
            rd_ack_r   <= rd_ack_nxt;
            nack_r     <= nack_nxt;
        end
    end

    // ---------------------------------------------------------------
    // threshold compares
    // ---------------------------------------------------------------
    logic signed [FX_W-1:0] meas_fx;
    logic signed [FX_W-1:0] ov_fx;
    logic signed [FX_W-1:0] uv_fx;
    logic signed [FX_W+7:0] meas_x100;
    logic signed [FX_W+7:0] ov_x90;
    logic signed [FX_W+7:0] ov_x95;
    logic signed [FX_W+7:0] uv_x110;
    logic                   ov_cond;
    logic                   ov_recov;
    logic                   ov_warn_cond;
    logic                   uv_cond;
    logic                   uv_warn_cond;

    lin11_to_fixed #(.OUT_W(FX_W), .FRAC(16)) u_meas (
        .word  (readback_r),
        .fixed (meas_fx)
    );
    lin11_to_fixed #(.OUT_W(FX_W), .FRAC(16)) u_ov (
        .word  (ov_thr_r),
        .fixed (ov_fx)
    );
    lin11_to_fixed #(.OUT_W(FX_W), .FRAC(16)) u_uv (
        .word  (uv_thr_r),
        .fixed (uv_fx)
    );

    always_comb begin
        meas_x100    = (FX_W+8)'(meas_fx) * $signed({1'b0, `PCT_FULL});
        ov_x90       = (FX_W+8)'(ov_fx) * $signed({1'b0, `OV_WARN_PCT});
        ov_x95       = (FX_W+8)'(ov_fx) * $signed({1'b0, `OV_RECOVER_PCT});
        uv_x110      = (FX_W+8)'(uv_fx) * $signed({1'b0, `UV_WARN_PCT});
        ov_cond      = seen_r && (meas_fx > ov_fx);
        ov_recov     = !seen_r || (meas_x100 < ov_x95);
        ov_warn_cond = seen_r && (meas_x100 > ov_x90);
        uv_cond      = seen_r && (meas_fx < uv_fx)
                    && (uv_resp_r.mode != `MODE_IGNORE);
        uv_warn_cond = seen_r && (meas_x100 < uv_x110);
    end

    // ---------------------------------------------------------------
    // overvoltage response state machine
    // ---------------------------------------------------------------
    aux_mon_pkg::ov_state_e state_r;
    aux_mon_pkg::ov_state_e state_nxt;
    logic [CNT_W-1:0]       timer_r;
    logic [CNT_W-1:0]       timer_nxt;
    logic                   run_cmd;
    logic                   ov_trip;

    always_comb begin
        state_nxt = state_r;
        timer_nxt = timer_r;
        run_cmd   = ctl_sync_r && operation_on && bias_ok
                 && !other_fault_off;
        ov_trip   = ov_cond && ((ov_resp_r.mode == `MODE_RETRY)
                 || (ov_resp_r.mode == `MODE_HOLD));
        if (timer_r != '0) begin
            timer_nxt = timer_r - 1'b1;
        end
        if (!run_cmd) begin
            state_nxt = aux_mon_pkg::ST_OFF;
            timer_nxt = '0;
        end else begin
            case (state_r)
                aux_mon_pkg::ST_OFF: begin
                    state_nxt = aux_mon_pkg::ST_RUN;
                end
                aux_mon_pkg::ST_RUN: begin
                    if (ov_trip && ov_resp_r.mode == `MODE_HOLD) begin
                        state_nxt = aux_mon_pkg::ST_HOLD;
                    end else if (ov_trip
                            && ov_resp_r.retry == `RETRY_CONT) begin
                        state_nxt = aux_mon_pkg::ST_RETRY;
                        timer_nxt = CNT_W'((32'(ov_resp_r.delay) + 1)
                                  * RETRY_UNIT_CYCLES);
                    end else if (ov_trip) begin
                        state_nxt = aux_mon_pkg::ST_LATCH;
                    end
                end
                aux_mon_pkg::ST_LATCH: begin
                    if (clear_faults) begin
                        state_nxt = aux_mon_pkg::ST_RUN;
                    end
                end
                aux_mon_pkg::ST_HOLD: begin
                    if (ov_recov) begin
                        state_nxt = aux_mon_pkg::ST_RUN;
                    end
                end
                aux_mon_pkg::ST_RETRY: begin
                    if (timer_r <= CNT_W'(1) && ov_recov) begin
                        state_nxt = aux_mon_pkg::ST_RUN;
                        timer_nxt = '0;
                    end
                end
                default: begin
                    state_nxt = aux_mon_pkg::ST_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= aux_mon_pkg::ST_OFF;
            timer_r <= '0;
        end else if (ce) begin
            state_r <= state_nxt;
            timer_r <= timer_nxt;
        end
    end

    // ---------------------------------------------------------------
    // sticky status, alert and output enable
    // ---------------------------------------------------------------
    aux_mon_pkg::status_s stat_r;
    aux_mon_pkg::status_s stat_nxt;
    logic                 alert_n_r;
    logic                 alert_n_nxt;
    logic                 out_en_r;
    logic                 out_en_nxt;

    // a set in the clearing cycle wins over the clear
    always_comb begin
        stat_nxt = clear_faults ? '0 : stat_r;
        if (ov_trip && state_r == aux_mon_pkg::ST_RUN) begin
            stat_nxt.ov_fault = 1'b1;
        end
        if (uv_cond) begin
            stat_nxt.uv_fault = 1'b1;
        end
        if (ov_warn_cond) begin
            stat_nxt.ov_warn = 1'b1;
        end
        if (uv_warn_cond) begin
            stat_nxt.uv_warn = 1'b1;
        end
        alert_n_nxt = !(stat_nxt.ov_fault || stat_nxt.uv_fault);
        out_en_nxt  = (state_nxt == aux_mon_pkg::ST_RUN);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stat_r    <= '0;
            alert_n_r <= 1'b1;
            out_en_r  <= 1'b0;
        end else if (ce) begin
            stat_r    <= stat_nxt;
            alert_n_r <= alert_n_nxt;
            out_en_r  <= out_en_nxt;
        end
    end

    assign rd_data             = rd_data_r;
    assign rd_ack              = rd_ack_r;
    assign cmd_nack            = nack_r;
    assign output_enable       = out_en_r;
    assign alert_output_line_n = alert_n_r;
    assign fault_status        = stat_r;

endmodule // aux_voltage_fault_monitor

// ==== verilog/lin11_to_fixed.sv ====
// linear-11 word to signed fixed point converter
`timescale 1ns/1ps
`include "aux_mon_consts.svh"

module lin11_to_fixed #(
    parameter int OUT_W = 48,
    parameter int FRAC  = 16
) (
    input  wire logic [15:0]       word,
    output logic signed [OUT_W-1:0] fixed
);
    logic signed [4:0]       expo;
    logic signed [10:0]      mant;
    logic signed [OUT_W-1:0] mant_ext;
    int                      shift;

    // value = mantissa * 2^exponent, scaled by 2^FRAC
    always_comb begin
        expo     = $signed(word[`L11_EXP_MSB:`L11_EXP_LSB]);
        mant     = $signed(word[`L11_MANT_MSB:0]);
        mant_ext = OUT_W'(mant);
        shift    = int'(expo) + FRAC;
        if (shift >= 0) begin
            fixed = mant_ext <<< shift;
        end else begin
            fixed = mant_ext >>> (-shift);
        end
    end

endmodule // lin11_to_fixed
